// *** ppr_pkg.sv ***
// constants and types shared by the pin remapping fabric
// assumes a 100 MHz system clock and an axi4-lite register master
package ppr_pkg;

  // fabric dimensions: four groups of eight remappable pins
  localparam int PPR_NUM_IN = 24; // peripheral inputs with a select reg
  localparam int PPR_NUM_PIN = 32; // remappable pins
  localparam int PPR_GRP_PINS = 8; // pins in one group
  localparam int PPR_NUM_POUT = 14; // remappable peripheral outputs
  localparam int PPR_SEL_W = 4; // select field width, bits 3:0
  localparam int PPR_ADDR_W = 12; // byte address bits decoded

  // pin index = group * 8 + input select code; group order:
  // 0: port_a0 b3 b4 b15 b7 c7 c0 c5
  // 1: port_a1 b5 b1 b11 b8 a8 c8 a9
  // 2: port_a2 b6 a4 b13 b2 c6 c1 c3
  // 3: port_a3 b14 b0 b10 b9 c9 c2 c4

  // register map (byte addresses)
  localparam logic [11:0] PPR_IN_SEL_BASE = 12'h000; // 24 input selects
  localparam logic [11:0] PPR_OUT_SEL_BASE = 12'h080; // 32 output selects
  localparam logic [11:0] PPR_CFG_CTRL_OFS = 12'h100; // config_control_reg

  // field positions and reset values
  localparam int PPR_MAP_LOCK_BIT = 13; // map_write_lock in config reg
  localparam int PPR_ONE_SHOT_BIT = 29; // one_shot_lock_cfg in cfg word 3
  localparam logic [3:0] PPR_SEL_RST = 4'h0; // select reset: output no connect, input picks pin 0 of its group
  localparam logic PPR_LOCK_RST = 1'b0; // writes open after reset

  // input group boundaries, by input register index
  localparam int PPR_G1_FIRST = 5; // ext_irq_three_in_sel
  localparam int PPR_G2_FIRST = 11; // ext_irq_two_in_sel
  localparam int PPR_G3_FIRST = 19; // ext_irq_one_in_sel

  // idle level of each peripheral input (selects, cts, rx idle high)
  localparam logic [23:0] PPR_IN_IDLE = 24'h418308;

  // remappable peripheral output indices on the periph_out bus
  localparam int PPR_PO_SPI1_SS = 0; // spi1_slave_select
  localparam int PPR_PO_SPI2_SS = 1;
  localparam int PPR_PO_SPI1_DO = 2;
  localparam int PPR_PO_SPI2_DO = 3;
  localparam int PPR_PO_OC1 = 4; // output_compare_1, then 2..5
  localparam int PPR_PO_OC2 = 5;
  localparam int PPR_PO_OC3 = 6;
  localparam int PPR_PO_OC4 = 7;
  localparam int PPR_PO_OC5 = 8;
  localparam int PPR_PO_CMP1 = 9;
  localparam int PPR_PO_CMP2 = 10; // comparator_2_output
  localparam int PPR_PO_REFCLK = 11;
  localparam int PPR_PO_U1_RTS = 12;
  localparam int PPR_PO_U2_TX = 13;

  // output select codes, per pin group
  localparam logic [3:0] PPR_OC_SPI1_SS = 4'h3; // group 0
  localparam logic [3:0] PPR_OC_CMP_OC_LO = 4'h5; // oc1/oc2/oc4/oc3
  localparam logic [3:0] PPR_OC_CMP2 = 4'h7; // group 0 and 3 comparators
  localparam logic [3:0] PPR_OC_SPI1_DO = 4'h3; // groups 1 and 2
  localparam logic [3:0] PPR_OC_SPI2_DO = 4'h4; // groups 1 and 2
  localparam logic [3:0] PPR_OC_OC5 = 4'h6; // group 2
  localparam logic [3:0] PPR_OC_REFCLK = 4'h7; // group 2
  localparam logic [3:0] PPR_OC_U1_RTS = 4'h1; // group 3
  localparam logic [3:0] PPR_OC_U2_TX = 4'h2; // group 3
  localparam logic [3:0] PPR_OC_SPI2_SS = 4'h4; // group 3

  // axi response codes
  localparam logic [1:0] PPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPR_RESP_DECERR = 2'h3;

  // which register an address hits
  typedef enum logic [1:0] {
    PPR_HIT_NONE,
    PPR_HIT_IN,
    PPR_HIT_OUT,
    PPR_HIT_CFG
  } ppr_hit_t;

  typedef struct packed {
    ppr_hit_t hit;
    logic [4:0] idx;
  } ppr_dec_t;

endpackage

// *** ppr_pin_if.sv ***
// pin-side signals between the mapping logic and the pin arbiter
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ppr_pin_if #(parameter int N = 32);
  logic [N-1:0] remap_en; // a valid output code is mapped
  logic [N-1:0] remap_val; // level of the mapped peripheral output
  logic [N-1:0] gpio_val; // gpio / fixed-function level
  logic [N-1:0] gpio_oe_n; // gpio output enable, low drives
  logic [N-1:0] analog; // pin owned by an analog function
  logic [N-1:0] pin_out; // registered pin level
  logic [N-1:0] pin_oe_n; // registered enable, low drives
  modport fabric (output remap_en, output remap_val, output gpio_val,
    output gpio_oe_n, output analog, input pin_out, input pin_oe_n);
  modport arb (input remap_en, input remap_val, input gpio_val,
    input gpio_oe_n, input analog, output pin_out, output pin_oe_n);
endinterface

// *** ppr_pin_arb.sv ***
// per-pin owner arbitration: analog, then remap, then gpio
// assumes all inputs are already on the system clock
`timescale 1ns/1ps
module ppr_pin_arb
  import ppr_pkg::*;
#(
  parameter int N = PPR_NUM_PIN
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  ppr_pin_if.arb pins
);

  // registered pin drive
  typedef struct packed {
    logic [N-1:0] out;
    logic [N-1:0] oe_n;
  } ppr_arb_st_t;

  ppr_arb_st_t st_r; // current pin drive
  ppr_arb_st_t st_nxt; // next pin drive

  // choose an owner per pin
  always_comb
  begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++)
    begin
      if (pins.analog[i])
      begin
        // analog owns the pad, digital drive is released
        st_nxt.out[i] = 1'b0;
        st_nxt.oe_n[i] = 1'b1;
      end
      else if (pins.remap_en[i])
      begin
        // remapped output beats gpio and fixed digital
        st_nxt.out[i] = pins.remap_val[i];
        st_nxt.oe_n[i] = 1'b0;
      end
      else
      begin
        // nothing mapped: gpio keeps the pin
        st_nxt.out[i] = pins.gpio_val[i];
        st_nxt.oe_n[i] = pins.gpio_oe_n[i];
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= '{out: '0, oe_n: '1};
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign pins.pin_out = st_r.out;
  assign pins.pin_oe_n = st_r.oe_n;

endmodule

// *** ppr_remap.sv ***
// peripheral pin remapping fabric with axi4-lite register access
// assumes pin_in is asynchronous, all other inputs on sys_clk;
// unlock_ok comes from the system unlock sequencer
//
// Overview of operation
// - each peripheral input has 4-bit pin select
// - group 0 codes pick a0 b3 b4 b15 b7 c7 c0 c5
// - group 1 codes pick a1 b5 b1 b11 b8 a8 c8 a9
// - group 2 codes pick a2 b6 a4 b13 b2 c6 c1 c3
// - group 3 codes pick a3 b14 b0 b10 b9 c9 c2 c4
// - input codes 8 to 15 route nothing
// - each pin has 4-bit peripheral output select
// - output code zero, the reset value, drives nothing
// - input and output maps are fully independent
// - no default output pin; input selects reset to code 0, which picks a pin
// - remapped function beats gpio and digital peripherals
// - remapping never overrides a pin's analog function
// - analog modules and i2c never pass through here
// - locked select writes complete but change nothing
// - locked writes look normal on the bus
// - one-shot config stops lock clearing once set
// - under one-shot only reset clears the lock
// - unprogrammed one-shot config reads as set
// - select regs hold bits 3:0, rest read zero
// - group 0 outputs: 3 ss1, 5 oc1, 7 cmp2
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ppr_remap
  import ppr_pkg::*;
#(
  parameter logic [PPR_NUM_IN-1:0] IN_IDLE = PPR_IN_IDLE
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [PPR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PPR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic unlock_ok,
  input wire logic [31:0] device_config_word_3,
  input wire logic [PPR_NUM_PIN-1:0] pin_in,
  input wire logic [PPR_NUM_PIN-1:0] pin_analog,
  input wire logic [PPR_NUM_PIN-1:0] gpio_out,
  input wire logic [PPR_NUM_PIN-1:0] gpio_oe_n,
  input wire logic [PPR_NUM_POUT-1:0] periph_out,
  output logic [PPR_NUM_IN-1:0] periph_in,
  output logic [PPR_NUM_PIN-1:0] pin_out,
  output logic [PPR_NUM_PIN-1:0] pin_oe_n
);

  // whole module state
  typedef struct packed {
    logic [PPR_NUM_IN-1:0][3:0] in_sel; // per-input pin select
    logic [PPR_NUM_PIN-1:0][3:0] out_sel; // per-pin output select
    logic lock; // map_write_lock
    logic aw_got; // write address held
    logic [PPR_ADDR_W-1:0] aw_addr;
    logic w_got; // write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [PPR_NUM_PIN-1:0] sync1; // first sync stage, only sync2 reads
    logic [PPR_NUM_PIN-1:0] sync2; // pin levels on sys_clk
    logic [PPR_NUM_IN-1:0] pin_view; // registered peripheral inputs
  } ppr_st_t;

  ppr_st_t st_r; // current state
  ppr_st_t st_nxt; // next state

  ppr_pin_if #(.N(PPR_NUM_PIN)) pin_bus ();

  // byte address to register kind and index
  function automatic ppr_dec_t ppr_decode(input logic [11:0] a);
    ppr_dec_t d;
    logic [9:0] w;
    w = a[11:2];
    d.hit = PPR_HIT_NONE;
    d.idx = 5'h00;
    if (w < PPR_OUT_SEL_BASE[11:2])
    begin
      // input selects sit at word 0 upward
      if (w < 10'(PPR_NUM_IN))
      begin
        d.hit = PPR_HIT_IN;
        d.idx = w[4:0];
      end
    end
    else if (w < PPR_CFG_CTRL_OFS[11:2])
    begin
      // output selects: low five bits are the pin index
      d.hit = PPR_HIT_OUT;
      d.idx = w[4:0];
    end
    else if (w == PPR_CFG_CTRL_OFS[11:2])
    begin
      d.hit = PPR_HIT_CFG;
    end
    return d;
  endfunction

  // group number of an input select register
  function automatic logic [1:0] ppr_in_group(input int i);
    if (i < PPR_G1_FIRST)
      return 2'h0;
    else if (i < PPR_G2_FIRST)
      return 2'h1;
    else if (i < PPR_G3_FIRST)
      return 2'h2;
    else
      return 2'h3;
  endfunction

  // peripheral output chosen by a pin's code: {enable, level}
  function automatic logic [1:0] ppr_out_pick(
    input logic [1:0] grp,
    input logic [3:0] code,
    input logic [PPR_NUM_POUT-1:0] po
  );
    logic [1:0] r;
    r = 2'b00; // no connect and reserved codes drive nothing
    unique case (grp)
      2'h0:
      begin
        // first pin group codes
        if (code == PPR_OC_SPI1_SS)
          r = {1'b1, po[PPR_PO_SPI1_SS]};
        else if (code == PPR_OC_CMP_OC_LO)
          r = {1'b1, po[PPR_PO_OC1]};
        else if (code == PPR_OC_CMP2)
          r = {1'b1, po[PPR_PO_CMP2]};
      end
      2'h1:
      begin
        if (code == PPR_OC_SPI1_DO)
          r = {1'b1, po[PPR_PO_SPI1_DO]};
        else if (code == PPR_OC_SPI2_DO)
          r = {1'b1, po[PPR_PO_SPI2_DO]};
        else if (code == PPR_OC_CMP_OC_LO)
          r = {1'b1, po[PPR_PO_OC2]};
      end
      2'h2:
      begin
        if (code == PPR_OC_SPI1_DO)
          r = {1'b1, po[PPR_PO_SPI1_DO]};
        else if (code == PPR_OC_SPI2_DO)
          r = {1'b1, po[PPR_PO_SPI2_DO]};
        else if (code == PPR_OC_CMP_OC_LO)
          r = {1'b1, po[PPR_PO_OC4]};
        else if (code == PPR_OC_OC5)
          r = {1'b1, po[PPR_PO_OC5]};
        else if (code == PPR_OC_REFCLK)
          r = {1'b1, po[PPR_PO_REFCLK]};
      end
      2'h3:
      begin
        if (code == PPR_OC_U1_RTS)
          r = {1'b1, po[PPR_PO_U1_RTS]};
        else if (code == PPR_OC_U2_TX)
          r = {1'b1, po[PPR_PO_U2_TX]};
        else if (code == PPR_OC_SPI2_SS)
          r = {1'b1, po[PPR_PO_SPI2_SS]};
        else if (code == PPR_OC_CMP_OC_LO)
          r = {1'b1, po[PPR_PO_OC3]};
        else if (code == PPR_OC_CMP2)
          r = {1'b1, po[PPR_PO_CMP1]};
      end
    endcase
    return r;
  endfunction

  // bus channel handshakes, taken only while ce runs
  logic aw_take; // address beat taken this edge
  logic w_take; // data beat taken this edge
  logic ar_take; // read address taken this edge
  logic one_shot; // one_shot_lock_cfg, 1 when unprogrammed

  assign s_axi_awready = ce && !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = ce && !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = ce && !st_r.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // erased fuse word reads all ones, so one-way is on by default
  assign one_shot = device_config_word_3[PPR_ONE_SHOT_BIT];

  // next-state logic: bus slave, lock, input routing
  always_comb
  begin
    logic [PPR_ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    ppr_dec_t dec;
    logic [1:0] grp;
    logic [3:0] code;
    logic [4:0] pin;
    wa = st_r.aw_addr;
    wd = st_r.wdata;
    ws = st_r.wstrb;
    dec = '{hit: PPR_HIT_NONE, idx: 5'h00};
    grp = 2'h0;
    code = 4'h0;
    pin = 5'h00;
    st_nxt = st_r;

    // catch each write beat, either order
    if (aw_take)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
      wa = s_axi_awaddr;
    end
    if (w_take)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
      wd = s_axi_wdata;
      ws = s_axi_wstrb;
    end

    // both beats present: apply the write and answer
    if (st_nxt.aw_got && st_nxt.w_got)
    begin
      dec = ppr_decode(wa);
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      // locked writes still answer okay, no stall
      st_nxt.bresp = (dec.hit == PPR_HIT_NONE) ?
        PPR_RESP_DECERR : PPR_RESP_OKAY;
      unique case (dec.hit)
        PPR_HIT_IN:
        begin
          // only bits 3:0 stored, lock discards silently
          if (!st_r.lock && ws[0])
            st_nxt.in_sel[dec.idx] = wd[3:0];
        end
        PPR_HIT_OUT:
        begin
          if (!st_r.lock && ws[0])
            st_nxt.out_sel[dec.idx] = wd[3:0];
        end
        PPR_HIT_CFG:
        begin
          // lock moves only after the unlock sequence
          if (unlock_ok && ws[1])
          begin
            if (wd[PPR_MAP_LOCK_BIT])
              st_nxt.lock = 1'b1;
            else if (!(one_shot && st_r.lock))
              st_nxt.lock = 1'b0; // one-shot keeps it set
          end
        end
        PPR_HIT_NONE:
        begin
          // unmapped: nothing stored, decode error returned
        end
      endcase
    end

    // write response leaves on bready
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;

    // read: data captured at the address beat
    if (ar_take)
    begin
      dec = ppr_decode(s_axi_araddr);
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = PPR_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000; // unimplemented bits read zero
      unique case (dec.hit)
        PPR_HIT_IN:
          st_nxt.rdata[3:0] = st_r.in_sel[dec.idx];
        PPR_HIT_OUT:
          st_nxt.rdata[3:0] = st_r.out_sel[dec.idx];
        PPR_HIT_CFG:
        begin
          st_nxt.rdata[PPR_MAP_LOCK_BIT] = st_r.lock;
          st_nxt.rdata[PPR_ONE_SHOT_BIT] = one_shot;
        end
        PPR_HIT_NONE:
          st_nxt.rresp = PPR_RESP_DECERR;
      endcase
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end

    // pins cross into sys_clk through two flops
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;

    // route one pin of the group to each peripheral input
    for (int i = 0; i < PPR_NUM_IN; i++)
    begin
      grp = ppr_in_group(i);
      code = st_r.in_sel[i];
      pin = {grp, code[2:0]}; // group * 8 + code
      if (code[3])
        st_nxt.pin_view[i] = IN_IDLE[i]; // reserved code
      else if (pin_analog[pin])
        st_nxt.pin_view[i] = IN_IDLE[i]; // analog pin reads idle
      else
        st_nxt.pin_view[i] = st_r.sync2[pin];
    end
  end

  // state register; output selects reset to no connection, input selects to code 0
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // device reset is the only way out of a one-shot lock
      st_r <= '0;
      st_r.in_sel <= {PPR_NUM_IN{PPR_SEL_RST}};
      st_r.out_sel <= {PPR_NUM_PIN{PPR_SEL_RST}};
      st_r.lock <= PPR_LOCK_RST;
      st_r.pin_view <= IN_IDLE;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  // per-pin remapped output, decoded from its group's table
  always_comb
  begin
    logic [1:0] pick;
    pick = 2'b00;
    for (int p = 0; p < PPR_NUM_PIN; p++)
    begin
      pick = ppr_out_pick(2'(p / PPR_GRP_PINS), st_r.out_sel[p],
        periph_out);
      pin_bus.remap_en[p] = pick[1];
      pin_bus.remap_val[p] = pick[0];
    end
  end

  // analog and i2c pads bypass the fabric
  assign pin_bus.gpio_val = gpio_out;
  assign pin_bus.gpio_oe_n = gpio_oe_n;
  assign pin_bus.analog = pin_analog;

  // pad owner arbitration
  ppr_pin_arb #(.N(PPR_NUM_PIN)) u_arb (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .pins(pin_bus.arb)
  );

  // registered outputs
  assign pin_out = pin_bus.pin_out;
  assign pin_oe_n = pin_bus.pin_oe_n;
  assign periph_in = st_r.pin_view;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

endmodule

// *** ppr_remap_properties.sv ***
// port checker for the pin remapping fabric, bound onto ppr_remap
// assumes one clock domain, sync active-high reset, ce held high
`timescale 1ns/1ps
module ppr_remap_properties
  import ppr_pkg::*;
#(
  parameter logic [PPR_NUM_IN-1:0] IN_IDLE = PPR_IN_IDLE
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [PPR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PPR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] device_config_word_3,
  input wire logic [PPR_NUM_PIN-1:0] pin_analog,
  input wire logic [PPR_NUM_IN-1:0] periph_in,
  input wire logic [PPR_NUM_PIN-1:0] pin_out,
  input wire logic [PPR_NUM_PIN-1:0] pin_oe_n
);
  logic [11:0] wa_r; // address of the write in flight
  logic [11:0] ra_r; // address of the read in flight
  logic w_map; // write address lands on a register

  // addresses of the transfers in flight
  always_ff @(posedge sys_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa_r <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ra_r <= s_axi_araddr;
  end

  // hole between the input and output select banks is unmapped
  assign w_map = wa_r < 12'h060 || (wa_r >= PPR_OUT_SEL_BASE &&
    wa_r < PPR_CFG_CTRL_OFS + 12'h004);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_b_prompt: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_b_okay: assert property ($rose(s_axi_bvalid) && w_map
    |-> s_axi_bresp == PPR_RESP_OKAY)
    else $error("mapped write not okay");
  a_no_ready_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pends");
  a_r_prompt: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_sel_upper: assert property (s_axi_rvalid && ra_r < PPR_CFG_CTRL_OFS
    && s_axi_rresp == PPR_RESP_OKAY |-> s_axi_rdata[31:4] == 28'h0)
    else $error("select upper bits not zero");
  a_cfg_mirror: assert property (s_axi_rvalid &&
    ra_r == PPR_CFG_CTRL_OFS |-> s_axi_rdata[29] == device_config_word_3[29])
    else $error("one-shot bit misread");
  a_analog_wins: assert property (ce |=>
    (pin_oe_n & $past(pin_analog)) == $past(pin_analog) &&
    (pin_out & $past(pin_analog)) == '0)
    else $error("analog pin driven");
  a_reset_state: assert property (disable iff (1'b0) rst |=>
    pin_oe_n == '1 && periph_in == IN_IDLE && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset state wrong");

  // main scenarios seen at the ports
  c_decerr: cover property ($rose(s_axi_bvalid) && !w_map);
  c_cfg_locked: cover property (s_axi_rvalid && ra_r == PPR_CFG_CTRL_OFS
    && s_axi_rdata[13]);
  c_remap_drive: cover property (pin_oe_n != '1 ##1 pin_oe_n != '1);
endmodule

bind ppr_remap ppr_remap_properties #(.IN_IDLE(IN_IDLE))
  ppr_remap_properties_inst (.*);

// *** tb.sv ***
// self-checking bench for the pin remapping fabric
// assumes the package and bound checker are compiled first
`timescale 1ns/1ps
module tb
  import ppr_pkg::*;
;
  logic sys_clk, rst, ce, unlock_ok; // clock, reset, enables
  logic [11:0] s_axi_awaddr, s_axi_araddr; // bus addresses
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready; // read handshake
  logic [31:0] s_axi_wdata, s_axi_rdata, device_config_word_3;
  logic [3:0] s_axi_wstrb; // always all lanes
  logic [1:0] s_axi_bresp, s_axi_rresp; // response codes
  logic [31:0] pin_in, pin_analog, gpio_out, gpio_oe_n, pin_out, pin_oe_n;
  logic [13:0] periph_out; // remappable peripheral outputs
  logic [23:0] periph_in; // routed peripheral inputs
  logic [31:0] rnd, rd_v; // random state, read data
  logic [1:0] rs; // last response
  logic [3:0] c; // select code under test
  logic eo; // expected pin_oe_n, 1 when the pin is not driven
  int i, s, err_total, compares;

  ppr_remap ppr_remap_inst (.*);

  // 100 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic int grp_of(input int k);
    return k < PPR_G1_FIRST ? 0 : k < PPR_G2_FIRST ? 1 :
      k < PPR_G3_FIRST ? 2 : 3;
  endfunction

  // expected level of input k; reserved or analog gives idle
  function automatic logic in_exp(input int k, input logic [3:0] cd);
    int p;
    p = grp_of(k) * PPR_GRP_PINS + int'(cd[2:0]);
    if (cd[3] || pin_analog[p])
      return PPR_IN_IDLE[k];
    return pin_in[p];
  endfunction

  // output picked by a pin code, -1 for none
  function automatic int out_src(input int g, input logic [3:0] cd);
    case ({2'(g), cd})
      6'h03: return PPR_PO_SPI1_SS;
      6'h05: return PPR_PO_OC1;
      6'h07: return PPR_PO_CMP2;
      6'h13, 6'h23: return PPR_PO_SPI1_DO;
      6'h14, 6'h24: return PPR_PO_SPI2_DO;
      6'h15: return PPR_PO_OC2;
      6'h25: return PPR_PO_OC4;
      6'h26: return PPR_PO_OC5;
      6'h27: return PPR_PO_REFCLK;
      6'h31: return PPR_PO_U1_RTS;
      6'h32: return PPR_PO_U2_TX;
      6'h34: return PPR_PO_SPI2_SS;
      6'h35: return PPR_PO_OC3;
      6'h37: return PPR_PO_CMP1;
      default: return -1;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // aw and w offered together; bready raised once both are gone
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid)
        s_axi_bready <= !(s_axi_bvalid && s_axi_bready);
    end
    while (s_axi_bvalid !== 1'b1 || !s_axi_bready);
    r = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (!s_axi_arvalid)
        s_axi_rready <= !(s_axi_rvalid && s_axi_rready);
    end
    while (s_axi_rvalid !== 1'b1 || !s_axi_rready);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog, well past the test length
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    {rst, ce, unlock_ok, s_axi_wstrb} = 7'h7f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, pin_in, pin_analog, gpio_out, gpio_oe_n} = '0;
    periph_out = '0;
    device_config_word_3 = 32'h2000_0000; // only bit 29 set: one-shot on
    rnd = 32'he40b;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // selects read zero, config only the mirror
    for (int j = 0; j < 57; j++)
    begin
      axi_rd(12'(j < 24 ? 4 * j : 4 * j + 32), rd_v, rs);
      chk(rd_v, j == 56 ? 32'h2000_0000 : 32'h0);
    end
    $display("test reset_values done");
    // codes 0..7 in each group, then reserved codes
    for (int j = 0; j < 48; j++)
    begin
      do
      begin
        rnd = lfsr(rnd);
        i = int'(rnd % 24);
      end
      while (j < 32 && grp_of(i) != j / 8);
      c = 4'(j % 8 + (j < 32 ? 0 : 8));
      axi_wr(12'(4 * i), {28'h0, c}, rs);
      axi_rd(12'(4 * i), rd_v, rs);
      chk(rd_v, {28'h0, c});
      pin_in <= lfsr(rnd);
      pin_analog <= rnd & lfsr(rnd);
      repeat (4) @(posedge sys_clk);
      chk(periph_in[i], in_exp(i, c));
    end
    $display("test input_map done");
    // codes 0..7 per pin group, then random
    for (int j = 0; j < 64; j++)
    begin
      rnd = lfsr(rnd);
      i = j < 32 ? j : int'(rnd % 32);
      c = j < 32 ? 4'(j % 8) : rnd[7:4];
      periph_out <= rnd[13:0];
      gpio_out <= lfsr(rnd);
      gpio_oe_n <= ~rnd;
      pin_analog <= rnd & lfsr(rnd);
      axi_wr(PPR_OUT_SEL_BASE + 12'(4 * i), {28'h0, c}, rs);
      axi_rd(PPR_OUT_SEL_BASE + 12'(4 * i), rd_v, rs);
      chk(rd_v, {28'h0, c});
      repeat (2) @(posedge sys_clk);
      s = out_src(i / 8, c);
      eo = pin_analog[i] || (s < 0 && gpio_oe_n[i]);
      chk(pin_oe_n[i], eo);
      if (!eo || pin_analog[i])
        chk(pin_out[i], !pin_analog[i] && (s >= 0 ? periph_out[s] :
          gpio_out[i]));
    end
    $display("test output_map done");
    // one-shot lock: writes answer okay, change nothing
    axi_wr(12'h000, 32'h2, rs);
    axi_wr(PPR_OUT_SEL_BASE, 32'h3, rs);
    axi_wr(PPR_CFG_CTRL_OFS, 32'h2000, rs);
    axi_wr(12'h000, 32'h6, rs);
    chk(rs, PPR_RESP_OKAY);
    axi_wr(PPR_OUT_SEL_BASE, 32'h5, rs);
    axi_wr(PPR_CFG_CTRL_OFS, 32'h0, rs);
    axi_rd(PPR_CFG_CTRL_OFS, rd_v, rs);
    chk(rd_v, 32'h2000_2000);
    axi_rd(12'h000, rd_v, rs);
    chk(rd_v, 32'h2);
    axi_rd(PPR_OUT_SEL_BASE, rd_v, rs);
    chk(rd_v, 32'h3);
    // only reset opens it; one-shot now programmed off
    rst <= 1'b1;
    device_config_word_3 <= 32'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    axi_rd(PPR_CFG_CTRL_OFS, rd_v, rs);
    chk(rd_v, 32'h0);
    axi_wr(PPR_CFG_CTRL_OFS, 32'h2000, rs);
    axi_wr(PPR_CFG_CTRL_OFS, 32'h0, rs);
    axi_wr(12'h000, 32'h7, rs);
    axi_rd(12'h000, rd_v, rs);
    chk(rd_v, 32'h7);
    unlock_ok <= 1'b0;
    axi_wr(PPR_CFG_CTRL_OFS, 32'h2000, rs);
    axi_rd(PPR_CFG_CTRL_OFS, rd_v, rs);
    chk(rd_v, 32'h0);
    axi_wr(12'h060, 32'h5, rs);
    chk(rs, PPR_RESP_DECERR);
    axi_rd(12'h060, rd_v, rs);
    chk(rd_v, 32'h0);
    chk(rs, PPR_RESP_DECERR);
    $display("test lock done");
    tally_and_finish();
  end
endmodule
